// *** shared/hbg_pkg.sv ***
// ****************************************************************
// Heartbeat and gear detect shared definitions
// ****************************************************************
package hbg_pkg;

  // Clock rate and derived timing
  localparam int unsigned HBG_CLK_HZ       = 100_000_000;
  localparam int unsigned HBG_MS_PER_S     = 1000;
  localparam int unsigned HBG_CYC_PER_MS   = HBG_CLK_HZ / HBG_MS_PER_S;
  // Whole identification pass, in seconds
  localparam int unsigned HBG_DETECT_S     = 60;

  // Gear layout
  localparam int unsigned HBG_NUM_CH       = 8;
  localparam int unsigned HBG_CH_W         = 3;
  localparam int unsigned HBG_GEAR_PER_CH  = 64;
  localparam int unsigned HBG_GEAR_W       = 6;
  localparam int unsigned HBG_CNT_W        = 7;
  localparam int unsigned HBG_SLOTS        = HBG_NUM_CH * HBG_GEAR_PER_CH;
  // Cycles per query slot so that one pass lasts the detection time
  localparam int unsigned HBG_SLOT_CYC     = HBG_DETECT_S * (HBG_CLK_HZ / HBG_SLOTS);

  // Register byte offsets
  localparam logic [7:0] HBG_OFS_CTRL      = 8'h00;
  localparam logic [7:0] HBG_OFS_CONFIG    = 8'h04;
  localparam logic [7:0] HBG_OFS_PERIOD    = 8'h08;
  localparam logic [7:0] HBG_OFS_STATUS    = 8'h0C;
  localparam logic [7:0] HBG_OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] HBG_OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0] HBG_OFS_COUNT0    = 8'h20;

  // Control fields
  localparam int unsigned HBG_CTRL_HB_EN   = 0;
  localparam int unsigned HBG_CTRL_DETECT  = 1;

  // Config fields: four 3-bit reactions and two flags
  localparam int unsigned HBG_CFG_COMM     = 0;
  localparam int unsigned HBG_CFG_SFAIL    = 3;
  localparam int unsigned HBG_CFG_SREC     = 6;
  localparam int unsigned HBG_CFG_BALLAST  = 9;
  localparam int unsigned HBG_CFG_INDIV    = 12;
  localparam int unsigned HBG_CFG_BURNIN   = 13;
  localparam int unsigned HBG_CFG_W        = 14;

  // Status fields
  localparam int unsigned HBG_ST_FAULT     = 0;
  localparam int unsigned HBG_ST_BUSY      = 1;
  localparam int unsigned HBG_ST_DONE      = 2;

  // Interrupt bits
  localparam int unsigned HBG_IRQ_W        = 4;
  localparam int unsigned HBG_IRQ_FAULT    = 0;
  localparam int unsigned HBG_IRQ_RECOVER  = 1;
  localparam int unsigned HBG_IRQ_DONE     = 2;
  localparam int unsigned HBG_IRQ_BALLAST  = 3;

  // Reset values
  localparam logic [HBG_CFG_W-1:0] HBG_CFG_RST    = 14'h0000;
  localparam logic [15:0]          HBG_PERIOD_RST = 16'h003C;
  localparam logic [HBG_IRQ_W-1:0] HBG_MASK_RST   = 4'h0;

  // Reaction choices, no change first so a zero field is the default
  typedef enum logic [2:0] {
    HBG_REACT_KEEP,
    HBG_REACT_START,
    HBG_REACT_MAX,
    HBG_REACT_MIN,
    HBG_REACT_OFF
  } hbg_react_t;

  // Object a telegram is addressed to
  typedef enum logic [1:0] {
    HBG_OBJ_HEARTBEAT,
    HBG_OBJ_DETECT,
    HBG_OBJ_OTHER
  } hbg_obj_t;

  // Incoming telegram
  typedef struct packed {
    hbg_obj_t   obj;
    logic [7:0] value;
  } hbg_tg_t;

  // Gear query towards the line logic
  typedef struct packed {
    logic [HBG_CH_W-1:0]   ch;
    logic [HBG_GEAR_W-1:0] addr;
  } hbg_query_t;

endpackage

// *** hdl/hbg_heartbeat_gear.sv ***
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module hbg_heartbeat_gear
  import hbg_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = HBG_CYC_PER_MS,
  parameter int unsigned SLOT_CYC   = HBG_SLOT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  // Register port
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [31:0]          reg_rdata,
  // Telegram input and forwarding
  input  wire logic                 tg_valid,
  input  wire hbg_tg_t              tg_in,
  output logic                      fwd_valid,
  output hbg_tg_t                   fwd_tg,
  // Fault state and reaction
  output logic                      safety_state,
  output logic                      react_apply,
  output hbg_react_t                react_code,
  output logic                      tx_tick,
  // Gear query handshake to line logic
  output logic                      query_req,
  output hbg_query_t                query,
  input  wire logic                 query_ack,
  input  wire logic                 query_present,
  output logic                      ballast_fail,
  // Interrupt
  output logic                      irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic                   hb_en_reg;                 // Heartbeat watch on
  logic [HBG_CFG_W-1:0]   cfg_reg;                   // Reaction settings
  logic [15:0]            period_reg;                // Period in seconds
  logic [HBG_IRQ_W-1:0]   irq_stat_reg;              // Sticky events
  logic [HBG_IRQ_W-1:0]   irq_mask_reg;              // Event enables
  logic [31:0]            rdata_reg;                 // Read data
  logic [HBG_CNT_W-1:0]   count_reg [HBG_NUM_CH];    // Gear per channel
  logic                   present_reg [HBG_SLOTS];   // Identified gear map

  // Decoded strobes
  logic                   wr_ctrl;
  logic                   sw_trigger;
  logic                   obj_trigger;
  logic                   trigger;

  // Events feeding the interrupt status
  logic [HBG_IRQ_W-1:0]   events;

  // Heartbeat timing
  logic [31:0]            pre_reg;                   // Cycle prescaler
  logic [31:0]            ms_reg;                    // Elapsed ms
  logic [31:0]            tx_ms_reg;                 // Transmit period ms
  logic                   ms_tick;
  logic [31:0]            period_ms;
  logic                   fault_reg;
  logic                   hb_one;
  logic                   timeout;

  // Detection sequencer
  typedef enum logic [1:0] {HBG_S_IDLE, HBG_S_WAIT, HBG_S_ASK} hbg_state_t;
  hbg_state_t             state_reg;
  logic                   detecting_reg;             // First pass running
  logic                   done_reg;                  // Identification done
  logic [31:0]            slot_reg;                  // Slot pacing counter
  logic [8:0]             idx_reg;                   // Channel and gear index
  logic                   slot_end;

  // Channel and gear address from the flat index
  function automatic hbg_query_t idx_to_query(input logic [8:0] idx);
    hbg_query_t q;
    q.ch   = idx[8:6];
    q.addr = idx[5:0];
    return q;
  endfunction

  assign wr_ctrl     = reg_write && (reg_addr == HBG_OFS_CTRL);
  assign sw_trigger  = wr_ctrl && reg_wdata[HBG_CTRL_DETECT];
  // Detect object is dropped in the safety state, like every telegram but a heartbeat one
  assign obj_trigger = tg_valid && (tg_in.obj == HBG_OBJ_DETECT) && !fault_reg
                       && (tg_in.value[0] == 1'b1);
  assign trigger     = sw_trigger || obj_trigger;

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  // power-up defaults
  always_ff @(posedge clk) begin
    if (reset) begin
      hb_en_reg    <= 1'b0;
      cfg_reg      <= HBG_CFG_RST;
      period_reg   <= HBG_PERIOD_RST;
      irq_mask_reg <= HBG_MASK_RST;
    end else if (reg_write) begin
      unique case (reg_addr)
        HBG_OFS_CTRL:     hb_en_reg    <= reg_wdata[HBG_CTRL_HB_EN];
        HBG_OFS_CONFIG:   cfg_reg      <= reg_wdata[HBG_CFG_W-1:0];
        // one period serves receive and transmit
        HBG_OFS_PERIOD:   period_reg   <= reg_wdata[15:0];
        HBG_OFS_IRQ_MASK: irq_mask_reg <= reg_wdata[HBG_IRQ_W-1:0];
        default: begin
          // Other offsets hold no state written in this block
        end
      endcase
    end
  end

  // ****************************************************************
  // Millisecond base and heartbeat timeout
  // ****************************************************************
  assign ms_tick   = (pre_reg == 32'(CYC_PER_MS - 1));
  assign period_ms = 32'(period_reg) * 32'(HBG_MS_PER_S);
  // the far end writes one to this object
  assign hb_one    = tg_valid && (tg_in.obj == HBG_OBJ_HEARTBEAT) && (tg_in.value[0] == 1'b1);
  // A zero period would fault at once, so it counts as no watch
  assign timeout   = hb_en_reg && (period_reg != 16'h0000) && !fault_reg
                     && ms_tick && (ms_reg + 32'h0000_0001 >= period_ms);

  // Prescaler runs freely
  always_ff @(posedge clk) begin
    if (reset) begin
      pre_reg <= 32'h0000_0000;
    end else if (ms_tick) begin
      pre_reg <= 32'h0000_0000;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  // Receive interval counter
  always_ff @(posedge clk) begin
    if (reset) begin
      ms_reg <= 32'h0000_0000;
    end else if (hb_one || !hb_en_reg || fault_reg) begin
      ms_reg <= 32'h0000_0000;
    end else if (ms_tick) begin
      ms_reg <= ms_reg + 32'h0000_0001;
    end
  end

  // Transmit period tick for the status sender
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_ms_reg <= 32'h0000_0000;
      tx_tick   <= 1'b0;
    end else begin
      tx_tick <= 1'b0;
      if (ms_tick) begin
        if (tx_ms_reg + 32'h0000_0001 >= period_ms) begin
          tx_ms_reg <= 32'h0000_0000;
          tx_tick   <= (period_reg != 16'h0000);
        end else begin
          tx_ms_reg <= tx_ms_reg + 32'h0000_0001;
        end
      end
    end
  end

  // Fault flag and reaction pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_reg   <= 1'b0;
      react_apply <= 1'b0;
      react_code  <= HBG_REACT_KEEP;
    end else begin
      react_apply <= 1'b0;
      if (timeout) begin
        fault_reg   <= 1'b1;
        react_apply <= 1'b1;
        react_code  <= hbg_react_t'(cfg_reg[HBG_CFG_COMM +: 3]);
      end else if (fault_reg && hb_one) begin
        fault_reg <= 1'b0;
      end
    end
  end

  assign safety_state = fault_reg;

  // ****************************************************************
  // Telegram forwarding
  // ****************************************************************
  // nothing passes in fault; only other objects are forwarded
  always_ff @(posedge clk) begin
    if (reset) begin
      fwd_valid <= 1'b0;
      fwd_tg    <= '0;
    end else begin
      fwd_valid <= tg_valid && !fault_reg && (tg_in.obj == HBG_OBJ_OTHER);
      if (tg_valid) begin
        fwd_tg <= tg_in;
      end
    end
  end

  // ****************************************************************
  // Gear identification and monitoring
  // ****************************************************************
  assign slot_end  = (slot_reg == 32'(SLOT_CYC - 1));
  assign query_req = (state_reg == HBG_S_ASK);
  assign query     = idx_to_query(idx_reg);

  // Sequencer: one query per slot, first pass identifies, later passes watch
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg     <= HBG_S_IDLE;
      detecting_reg <= 1'b0;
      done_reg      <= 1'b0;
      slot_reg      <= 32'h0000_0000;
      idx_reg       <= 9'h000;
    end else if (trigger) begin
      state_reg     <= HBG_S_WAIT;
      detecting_reg <= 1'b1;
      done_reg      <= 1'b0;
      slot_reg      <= 32'h0000_0000;
      idx_reg       <= 9'h000;
    end else begin
      unique case (state_reg)
        HBG_S_IDLE: begin
          slot_reg <= 32'h0000_0000;
        end
        HBG_S_WAIT: begin
          slot_reg <= slot_end ? 32'h0000_0000 : slot_reg + 32'h0000_0001;
          // only identified gear is polled after the first pass
          if (slot_end && (detecting_reg || present_reg[idx_reg])) begin
            state_reg <= HBG_S_ASK;
          end else if (slot_end) begin
            idx_reg <= idx_reg + 9'h001;
          end
        end
        HBG_S_ASK: begin
          // Slot counter keeps pacing while the line answers
          slot_reg <= slot_end ? 32'h0000_0000 : slot_reg + 32'h0000_0001;
          if (query_ack) begin
            state_reg <= HBG_S_WAIT;
            idx_reg   <= idx_reg + 9'h001;
            if (idx_reg == 9'(HBG_SLOTS - 1) && detecting_reg) begin
              detecting_reg <= 1'b0;
              done_reg      <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < HBG_SLOTS; i++) begin
        present_reg[i] <= 1'b0;
      end
      for (int c = 0; c < HBG_NUM_CH; c++) begin
        count_reg[c] <= '0;
      end
    end else if (trigger) begin
      for (int i = 0; i < HBG_SLOTS; i++) begin
        present_reg[i] <= 1'b0;
      end
      for (int c = 0; c < HBG_NUM_CH; c++) begin
        count_reg[c] <= '0;
      end
    end else if (query_req && query_ack && detecting_reg && query_present) begin
      present_reg[idx_reg] <= 1'b1;
      count_reg[query.ch]  <= count_reg[query.ch] + 7'h01;
    end
  end

  // A watched gear that stays silent is a ballast failure
  always_ff @(posedge clk) begin
    if (reset) begin
      ballast_fail <= 1'b0;
    end else begin
      ballast_fail <= query_req && query_ack && !detecting_reg && !query_present;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  always_comb begin
    events                  = '0;
    events[HBG_IRQ_FAULT]   = timeout;
    events[HBG_IRQ_RECOVER] = fault_reg && hb_one;
    events[HBG_IRQ_DONE]    = query_req && query_ack && detecting_reg && !trigger
                              && (idx_reg == 9'(HBG_SLOTS - 1));
    events[HBG_IRQ_BALLAST] = query_req && query_ack && !detecting_reg && !query_present;
  end

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_reg <= '0;
    end else begin
      if (reg_write && (reg_addr == HBG_OFS_IRQ_STAT)) begin
        irq_stat_reg <= (irq_stat_reg & ~reg_wdata[HBG_IRQ_W-1:0]) | events;
      end else begin
        irq_stat_reg <= irq_stat_reg | events;
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************************************
  // Register read
  // ****************************************************************
  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= 32'h0000_0000;
    end else if (reg_read) begin
      rdata_reg <= 32'h0000_0000;
      if (reg_addr >= HBG_OFS_COUNT0 && reg_addr < HBG_OFS_COUNT0 + 8'h20
          && reg_addr[1:0] == 2'b00) begin
        rdata_reg <= 32'(count_reg[reg_addr[4:2]]);
      end else begin
        unique case (reg_addr)
          HBG_OFS_CTRL:     rdata_reg <= 32'(hb_en_reg);
          HBG_OFS_CONFIG:   rdata_reg <= 32'(cfg_reg);
          HBG_OFS_PERIOD:   rdata_reg <= 32'(period_reg);
          HBG_OFS_STATUS:   rdata_reg <= 32'({done_reg, detecting_reg, fault_reg});
          HBG_OFS_IRQ_STAT: rdata_reg <= 32'(irq_stat_reg);
          HBG_OFS_IRQ_MASK: rdata_reg <= 32'(irq_mask_reg);
          default:          rdata_reg <= 32'h0000_0000;
        endcase
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule // hbg_heartbeat_gear

// *** verification/hbg_line_model.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Line side gear model
// ****************************************************************
module hbg_line_model
  import hbg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       query_req,
  input  wire hbg_query_t query,
  input  wire logic       drop,
  output logic            query_ack,
  output logic            query_present
);
  logic [1:0] wait_reg;  // Cycles spent on the open query
  logic       pres;      // Gear fitted at the queried slot
  // Gear 0..ch fitted on channel ch; drop removes gear 0 of channel 0
  assign pres = (query.addr <= 6'(query.ch)) && !(drop && query == '0);
  // Odd slots answer late, even ones at once; an idle present line toggles
  always_ff @(posedge clk) begin
    if (reset) begin
      query_ack     <= 1'b0;
      query_present <= 1'b0;
      wait_reg      <= 2'd0;
    end else if (query_req && !query_ack && wait_reg == {2{query.addr[0]}}) begin
      query_ack     <= 1'b1;
      query_present <= pres;
      wait_reg      <= 2'd0;
    end else begin
      query_ack     <= 1'b0;
      query_present <= ~query_present;
      wait_reg      <= (query_req && !query_ack) ? wait_reg + 2'd1 : 2'd0;
    end
  end
endmodule // hbg_line_model

// *** verification/hbg_checker_asserts.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Port checker
// ****************************************************************
module hbg_checker
  import hbg_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = HBG_CYC_PER_MS,
  parameter int unsigned SLOT_CYC   = HBG_SLOT_CYC
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        tg_valid,
  input wire hbg_tg_t     tg_in,
  input wire logic        fwd_valid,
  input wire logic        safety_state,
  input wire logic        react_apply,
  input wire hbg_react_t  react_code,
  input wire logic        query_req,
  input wire hbg_query_t  query,
  input wire logic        query_ack,
  input wire logic        query_present
);
  logic armed_reg;  // A detection trigger has been seen since reset
  logic hb_one;     // Heartbeat telegram carrying one
  logic trig_seen;  // A detection trigger is taken this cycle
  assign hb_one = tg_valid && tg_in.obj == HBG_OBJ_HEARTBEAT && tg_in.value[0];
  // A detect telegram counts only outside a fault, where it is not dropped
  assign trig_seen = (reg_write && reg_addr == HBG_OFS_CTRL && reg_wdata[HBG_CTRL_DETECT])
                     || (tg_valid && tg_in.obj == HBG_OBJ_DETECT && tg_in.value[0]
                         && !safety_state);
  // Arm on either trigger path
  always_ff @(posedge clk) begin
    if (reset) begin
      armed_reg <= 1'b0;
    end else if (trig_seen) begin
      armed_reg <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_fault_entry: assert property (react_apply == $rose(safety_state))
    else $error("reaction pulse not at fault entry");
  a_react_range: assert property (react_apply |-> react_code <= HBG_REACT_OFF)
    else $error("reaction code out of range");
  a_fault_drops: assert property (safety_state |=> !fwd_valid)
    else $error("telegram passed during fault");
  a_fwd_other: assert property (tg_valid && tg_in.obj == HBG_OBJ_OTHER && !safety_state
                                |=> fwd_valid)
    else $error("telegram not passed on");
  a_hb_resume: assert property (safety_state && hb_one |=> !safety_state)
    else $error("fault kept after heartbeat one");
  a_zero_holds: assert property (safety_state && !hb_one && !reg_write |=> safety_state)
    else $error("fault left without heartbeat one");
  a_no_self: assert property (!armed_reg |-> !query_req)
    else $error("detection ran without trigger");
  // A trigger restarts the walk and may cut an open query short
  a_query_hold: assert property (
    query_req && !query_ack && !trig_seen |=> query_req && $stable(query))
    else $error("query dropped before answer");
  a_query_step: assert property (query_req && query_ack |=> !query_req)
    else $error("query kept after answer");
  c_fault: cover property ($rose(safety_state));
  c_resume: cover property (safety_state && hb_one);
  c_absent: cover property (query_ack && !query_present);
  c_restart: cover property (query_req && trig_seen);
endmodule // hbg_checker
bind hbg_heartbeat_gear hbg_checker #(.CYC_PER_MS(CYC_PER_MS), .SLOT_CYC(SLOT_CYC)) chk_u (
  .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .tg_valid(tg_valid), .tg_in(tg_in), .fwd_valid(fwd_valid),
  .safety_state(safety_state), .react_apply(react_apply), .react_code(react_code),
  .query_req(query_req), .query(query), .query_ack(query_ack),
  .query_present(query_present));

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Heartbeat and gear detect testbench
// ****************************************************************
module tb_top;
  import hbg_pkg::*;
  logic        clk = 1'b0;          // 100 MHz system clock
  logic        reset = 1'b1;        // Held for ten cycles
  logic [7:0]  reg_addr = 8'h00;    // Register port
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic        tg_valid = 1'b0;     // Telegram strobe
  hbg_tg_t     tg_in = '0;
  logic        fwd_valid;
  hbg_tg_t     fwd_tg;
  logic        safety_state;
  logic        react_apply;
  hbg_react_t  react_code;
  logic        tx_tick;
  logic        query_req;
  hbg_query_t  query;
  logic        query_ack;
  logic        query_present;
  logic        ballast_fail;
  logic        irq;
  logic        drop = 1'b0;         // Removes one gear from the line model
  int          err_count = 0;
  int          num_checks = 0;
  // Clock
  always #5 clk = ~clk;
  // Short counts keep the one second watch at ten thousand cycles
  hbg_heartbeat_gear #(.CYC_PER_MS(10), .SLOT_CYC(4)) dut_u (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tg_valid(tg_valid), .tg_in(tg_in), .fwd_valid(fwd_valid), .fwd_tg(fwd_tg),
    .safety_state(safety_state), .react_apply(react_apply), .react_code(react_code),
    .tx_tick(tx_tick), .query_req(query_req), .query(query), .query_ack(query_ack),
    .query_present(query_present), .ballast_fail(ballast_fail), .irq(irq));
  hbg_line_model line_u (.clk(clk), .reset(reset), .query_req(query_req), .query(query),
    .drop(drop), .query_ack(query_ack), .query_present(query_present));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic tg(input hbg_obj_t o, input logic [7:0] v);
    @(posedge clk);
    tg_valid <= 1'b1;
    tg_in    <= '{obj: o, value: v};
    @(posedge clk);
    tg_valid <= 1'b0;
    #1;
  endtask
  task automatic t_defaults();
    logic [31:0] d;
    rd(HBG_OFS_CONFIG, d);
    chk("config", d, 32'h0000_0000);
    rd(HBG_OFS_PERIOD, d);
    chk("period", d, 32'h0000_003C);
    rd(HBG_OFS_IRQ_MASK, d);
    chk("mask", d, 32'h0000_0000);
    rd(8'h40, d);
    chk("unmapped", d, 32'h0000_0000);
    cyc(100);
    chk("idle query", query_req, 1'b0);
  endtask
  task automatic t_heartbeat();
    logic [31:0] d;
    int          n;
    wr(HBG_OFS_CONFIG, 32'h0000_0003);
    wr(HBG_OFS_PERIOD, 32'h0000_0001);
    wr(HBG_OFS_IRQ_MASK, 32'h0000_000F);
    wr(HBG_OFS_CTRL, 32'h0000_0001);
    tg(HBG_OBJ_HEARTBEAT, 8'h01);
    cyc(9000);
    tg(HBG_OBJ_HEARTBEAT, 8'h01);
    cyc(9000);
    chk("refreshed", safety_state, 1'b0);
    tg(HBG_OBJ_HEARTBEAT, 8'h00);
    cyc(1500);
    chk("timeout", safety_state, 1'b1);
    chk("reaction", react_code, HBG_REACT_MIN);
    chk("fault irq", irq, 1'b1);
    tg(HBG_OBJ_OTHER, 8'h5A);
    chk("dropped", fwd_valid, 1'b0);
    tg(HBG_OBJ_DETECT, 8'h01);
    cyc(20);
    chk("detect dropped", query_req, 1'b0);
    rd(HBG_OFS_STATUS, d);
    chk("detect ignored", d[HBG_ST_BUSY], 1'b0);
    tg(HBG_OBJ_HEARTBEAT, 8'h01);
    chk("resumed", safety_state, 1'b0);
    tg(HBG_OBJ_OTHER, 8'hA5);
    chk("passed", fwd_valid, 1'b1);
    chk("passed value", fwd_tg, 32'({HBG_OBJ_OTHER, 8'hA5}));
    rd(HBG_OFS_IRQ_STAT, d);
    chk("fault events", d, 32'h0000_0003);
    wr(HBG_OFS_CTRL, 32'h0000_0000);
    wr(HBG_OFS_IRQ_STAT, 32'h0000_000F);
    cyc(1);
    chk("irq cleared", irq, 1'b0);
    // Transmit beat shares the one second period
    n = 0;
    do begin @(posedge clk); #1; n++; end while (tx_tick !== 1'b1 && n < 12000);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (tx_tick !== 1'b1 && n < 12000);
    chk("beat spacing", n, 32'd10000);
  endtask
  task automatic t_detect();
    logic [31:0] d;
    int          n;
    wr(HBG_OFS_CTRL, 32'h0000_0002);
    cyc(2000);
    tg(HBG_OBJ_DETECT, 8'h01);
    n = 0;
    do begin @(posedge clk); #1; n++; end while (irq !== 1'b1 && n < 10000);
    chk("pass length", n >= 2048, 1'b1);
    rd(HBG_OFS_STATUS, d);
    chk("done", d[HBG_ST_DONE], 1'b1);
    for (int ch = 0; ch < HBG_NUM_CH; ch++) begin
      rd(HBG_OFS_COUNT0 + 8'(4 * ch), d);
      chk("gear count", d, 32'(ch + 1));
    end
    wr(HBG_OFS_IRQ_STAT, 32'h0000_000F);
    drop <= 1'b1;
    n = 0;
    // One watch pass over this gear set lasts about 2100 cycles
    do begin @(posedge clk); #1; n++; end while (ballast_fail !== 1'b1 && n < 3000);
    chk("ballast fail", ballast_fail, 1'b1);
    rd(HBG_OFS_IRQ_STAT, d);
    chk("ballast event", d[HBG_IRQ_BALLAST], 1'b1);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Watchdog, well past the expected run length
  initial begin
    #800_000;
    err_count++;
    results();
  end
  // Main sequence
  initial begin
    cyc(10);
    reset <= 1'b0;
    t_defaults();
    t_heartbeat();
    t_detect();
    results();
  end
endmodule // tb_top
